//--- design/strobe_bus_seq.sv
`timescale 1ns/100ps
module strobe_bus_seq
	import strobe_bus_pkg::*;
(
	input  wire logic                      clk,        // 40 MHz system clock
	input  wire logic                      rst_n,      // Asynchronous reset
	input  wire logic                      bus_clk,    // Expansion bus clock pin
	input  wire strobe_bus_pkg::phase_cfg_t phase_cfg, // Programmed phase counts
	input  wire logic                      req_valid,  // User asks for an access
	output logic                           req_ready,  // Access taken this cycle
	input  wire strobe_bus_pkg::access_t   req,        // Access details
	output logic                           busy,       // Access in progress
	output logic [strobe_bus_pkg::AD_W-1:0] rd_data,   // Captured read data
	output logic                           rd_valid,   // One-cycle read pulse
	input  wire logic [strobe_bus_pkg::AD_W-1:0] ad_in, // Shared lines in
	output strobe_bus_pkg::bus_pins_t      pins        // Pins to the peripheral
);
	import strobe_bus_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Checks on the shared constants
	if (SYNC_DEPTH != 2) begin : g_bad_sync
		$error("Synchroniser depth must be two");
	end
	if (SHORT_W > LONG_W) begin : g_bad_width
		$error("Short phase field wider than counter");
	end

	////////////////////////////////////////////////////////////////////////
	// Whole sequencer state
	typedef struct packed {
		logic            clk_s1;    // Bus clock, first sync flop
		logic            clk_s2;    // Bus clock, second sync flop
		logic            clk_prev;  // Bus clock one cycle older
		logic [AD_W-1:0] ad_s1;     // Lines, first sync flop
		logic [AD_W-1:0] ad_s2;     // Lines, second sync flop
		phase_t          ph;        // Current phase
		logic [LONG_W-1:0] cnt;     // Bus cycles left in the phase, minus one
		phase_cfg_t      cfg;       // Counts caught when the access was taken
		access_t         acc;       // Access caught when it was taken
		bus_pins_t       pins;      // Registered pin values
		logic [AD_W-1:0] rd_data;   // Last read data
		logic            rd_valid;  // Read data pulse
	} state_t;

	state_t st_q;  // Registered state
	state_t st_d;  // Next state
	logic   bus_edge;  // Rising edge of the bus clock seen this cycle

	////////////////////////////////////////////////////////////////////////
	// Phase order, shared by the sequencer and its checks
	function automatic phase_t next_phase(input phase_t p);
		phase_t n;
		n = PH_IDLE;
		case (p)
			PH_IDLE:   n = PH_ARM;
			PH_ARM:    n = PH_ADDR;
			PH_ADDR:   n = PH_AHOLD;
			PH_AHOLD:  n = PH_SETUP;
			PH_SETUP:  n = PH_STROBE;
			PH_STROBE: n = PH_HOLD;
			PH_HOLD:   n = PH_RECOV;
			default:   n = PH_IDLE;
		endcase
		return n;
	endfunction

	// Widen a short field to the counter width
	function automatic logic [LONG_W-1:0] widen(input logic [SHORT_W-1:0] f);
		return {{(LONG_W-SHORT_W){1'b0}}, f};
	endfunction

	// Counter load for the phase being entered
	function automatic logic [LONG_W-1:0] phase_load(input phase_t p, input phase_cfg_t c);
		logic [LONG_W-1:0] v;
		v = '0;
		case (p)
			PH_ADDR:   v = widen(c.address_phase_count);
			PH_AHOLD:  v = ADDR_HOLD_LOAD;
			PH_SETUP:  v = widen(c.data_setup_phase_count);
			PH_STROBE: v = c.strobe_phase_count;
			PH_HOLD:   v = widen(c.hold_phase_count);
			PH_RECOV:  v = c.recovery_phase_count;
			default:   v = '0;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Handshake and outputs
	assign bus_edge  = st_q.clk_s2 & ~st_q.clk_prev;  // Reads the second flop and its one-cycle-older copy only
	assign req_ready = (st_q.ph == PH_IDLE);          // Taken in any idle cycle
	assign busy      = (st_q.ph != PH_IDLE);
	assign rd_data   = st_q.rd_data;
	assign rd_valid  = st_q.rd_valid;
	assign pins      = st_q.pins;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: every phase but idle advances only on a bus clock edge, so the
	// pins move a few system cycles after the edge; the peripheral sees
	// whole bus cycles per phase.
	always_comb begin
		st_d          = st_q;
		st_d.clk_s1   = bus_clk;
		st_d.clk_s2   = st_q.clk_s1;
		st_d.clk_prev = st_q.clk_s2;
		st_d.ad_s1    = ad_in;
		st_d.ad_s2    = st_q.ad_s1;
		st_d.rd_valid = 1'b0;
		case (st_q.ph)
			PH_IDLE: begin
				// Take the request and put the address out at once, so it is
				// settled at least one system cycle before the latch pulse rises
				if (req_valid) begin
					st_d.acc          = req;
					st_d.cfg          = phase_cfg;
					st_d.ph           = PH_ARM;
					st_d.pins.ad_out  = req.addr;
					st_d.pins.ad_oe_n = 1'b0;
					st_d.pins.rnw     = ~req.write;
				end
			end
			PH_ARM: begin
				// Latch pulse starts on the next bus edge
				if (bus_edge) begin
					st_d.ph                       = PH_ADDR;
					st_d.cnt                      = phase_load(PH_ADDR, st_q.cfg);
					st_d.pins.address_latch_pulse = 1'b1;
				end
			end
			default: begin
				// Counted phases; the counter holds cycles left minus one
				if (bus_edge) begin
					if (st_q.cnt != '0) begin
						st_d.cnt = st_q.cnt - 4'h1;
					end else begin
						st_d.ph  = next_phase(st_q.ph);
						st_d.cnt = phase_load(st_d.ph, st_q.cfg);
						case (st_q.ph)
							PH_ADDR: begin
								// Pulse falls, address stays one fixed cycle
								st_d.pins.address_latch_pulse = 1'b0;
							end
							PH_AHOLD: begin
								// Select one cycle after the pulse fell; write
								// data leads the strobe by the setup count
								st_d.pins.sel_n = 1'b0;
								if (st_q.acc.write) begin
									st_d.pins.ad_out = st_q.acc.wdata;
								end else begin
									st_d.pins.ad_oe_n = 1'b1;
								end
							end
							PH_SETUP: begin
								// Strobe low for the strobe count
								st_d.pins.data_strobe_n = 1'b0;
							end
							PH_STROBE: begin
								// Strobe rises; read data sampled at that edge
								st_d.pins.data_strobe_n = 1'b1;
								if (!st_q.acc.write) begin
									st_d.rd_data  = st_q.ad_s2;
									st_d.rd_valid = 1'b1;
								end
							end
							PH_HOLD: begin
								// Select, direction and lines let go for recovery
								st_d.pins.sel_n   = 1'b1;
								st_d.pins.ad_oe_n = 1'b1;
								st_d.pins.rnw     = 1'b1;
							end
							default: begin
								// Recovery done, idle again
								st_d.cnt = '0;
							end
						endcase
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q                          <= '0;
			st_q.ph                       <= PH_IDLE;
			st_q.pins.address_latch_pulse <= RST_LATCH;
			st_q.pins.sel_n               <= RST_SEL_N;
			st_q.pins.rnw                 <= RST_RNW;
			st_q.pins.data_strobe_n       <= RST_DS_N;
			st_q.pins.ad_out              <= RST_AD;
			st_q.pins.ad_oe_n             <= RST_OE_N;
			{st_q.clk_s1, st_q.clk_s2, st_q.clk_prev} <= {3{RST_BCLK}};  // A high pin at release is no edge
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checking helpers: bus edges seen in the current phase
	logic [LONG_W:0] span_q;  // Edges counted since the phase began
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			span_q <= '0;
		end else if (st_d.ph != st_q.ph) begin
			span_q <= '0;
		end else if (bus_edge) begin
			span_q <= span_q + 5'h01;
		end
	end

	logic leaving;  // Phase ends on this cycle
	assign leaving = bus_edge && (st_q.ph != PH_IDLE) && (st_q.ph != PH_ARM) && (st_q.cnt == '0);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Pulse ending and the fixed address-hold cycle that follows
	sequence s_pulse_end;
		leaving && st_q.ph == PH_ADDR;
	endsequence
	sequence s_hold_cycle;
		!pins.address_latch_pulse && !pins.ad_oe_n && pins.sel_n && pins.ad_out == st_q.acc.addr;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_latch_width: assert property (s_pulse_end |-> span_q == {1'b0, widen(st_q.cfg.address_phase_count)})
		else $error("Latch pulse width differs from address count");
	a_addr_hold: assert property (st_q.ph == PH_AHOLD |-> s_hold_cycle)
		else $error("Address not held after latch pulse");
	a_hold_once: assert property (leaving && st_q.ph == PH_AHOLD |-> span_q == 5'h00)
		else $error("Address hold after latch pulse is not one cycle");
	a_select_delay: assert property ($fell(pins.sel_n) |-> $past(st_q.ph) == PH_AHOLD && $past(span_q) < 5'h04)
		else $error("Chip select late after latch pulse");
	a_addr_early: assert property ($rose(pins.address_latch_pulse) |-> !pins.ad_oe_n && pins.ad_out == st_q.acc.addr)
		else $error("Address not valid at latch pulse rise");
	a_setup_lead: assert property ($fell(pins.data_strobe_n) && st_q.acc.write |->
		span_q == 5'h00 && $past(span_q) == {1'b0, widen(st_q.cfg.data_setup_phase_count)} && !pins.ad_oe_n)
		else $error("Write data lead before strobe wrong");
	a_strobe_width: assert property (leaving && st_q.ph == PH_STROBE |-> span_q == {1'b0, st_q.cfg.strobe_phase_count})
		else $error("Strobe width differs from strobe count");
	a_data_strobe: assert property (!pins.data_strobe_n |->
		(st_q.acc.write ? (!pins.ad_oe_n && pins.ad_out == st_q.acc.wdata) : pins.ad_oe_n))
		else $error("Lines not set for data during strobe");
	a_hold_stable: assert property (st_q.ph == PH_HOLD && $past(st_q.ph) == PH_HOLD |->
		$stable(pins.sel_n) && $stable(pins.ad_out) && $stable(pins.ad_oe_n) && !pins.sel_n)
		else $error("Select or data moved during hold");
	a_hold_width: assert property (leaving && st_q.ph == PH_HOLD |-> span_q == {1'b0, widen(st_q.cfg.hold_phase_count)})
		else $error("Hold width differs from hold count");
	a_recov_width: assert property (leaving && st_q.ph == PH_RECOV |-> span_q == {1'b0, st_q.cfg.recovery_phase_count})
		else $error("Recovery gap differs from recovery count");
	a_phase_order: assert property ($changed(st_q.ph) |-> st_q.ph == next_phase($past(st_q.ph)))
		else $error("Phase skipped or reordered");
	a_read_capture: assert property (leaving && st_q.ph == PH_STROBE && !st_q.acc.write |=>
		rd_valid && rd_data == $past(st_q.ad_s2))
		else $error("Read data not captured at strobe rise");

endmodule

//--- shared/strobe_bus_pkg.sv
package strobe_bus_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths of the shared lines and of the phase-count fields
	localparam int unsigned AD_W       = 16;  // Shared address/data lines
	localparam int unsigned SHORT_W    = 2;   // Field for 1..4 cycle phases
	localparam int unsigned LONG_W     = 4;   // Field for 1..16 cycle phases
	localparam int unsigned SYNC_DEPTH = 2;   // Flops on each pin before use

	////////////////////////////////////////////////////////////////////////
	// Phase lengths in bus clock cycles: field value plus one
	localparam logic [LONG_W-1:0] FIELD_BIAS      = 4'h1;  // Field 0 means one cycle
	localparam logic [LONG_W-1:0] ADDR_HOLD_CYC   = 4'h1;  // Fixed hold after latch pulse
	localparam logic [LONG_W-1:0] ADDR_HOLD_LOAD  = ADDR_HOLD_CYC - FIELD_BIAS;

	////////////////////////////////////////////////////////////////////////
	// Reset values of the pins
	localparam logic          RST_LATCH  = 1'b0;         // Latch pulse low
	localparam logic          RST_SEL_N  = 1'b1;         // Chip select off
	localparam logic          RST_RNW    = 1'b1;         // Direction reads
	localparam logic          RST_DS_N   = 1'b1;         // Strobe off
	localparam logic          RST_OE_N   = 1'b1;         // Lines released
	localparam logic [AD_W-1:0] RST_AD   = 16'h0000;     // Idle line value
	localparam logic          RST_BCLK   = 1'b1;         // Bus clock flops start high, so no false edge

	////////////////////////////////////////////////////////////////////////
	// Access phases, in the order every access walks them
	typedef enum logic [2:0] {
		PH_IDLE,     // No access, waiting for a request
		PH_ARM,      // Address driven, waiting for a bus clock edge
		PH_ADDR,     // Latch pulse high
		PH_AHOLD,    // Latch pulse low, address still on the lines
		PH_SETUP,    // Chip select on, write data ahead of the strobe
		PH_STROBE,   // Data strobe low
		PH_HOLD,     // Strobe high, select and data held
		PH_RECOV     // Gap before the next access
	} phase_t;

	// Programmed phase counts, each field is length minus one
	typedef struct packed {
		logic [SHORT_W-1:0] address_phase_count;     // Latch pulse, 1..4
		logic [SHORT_W-1:0] data_setup_phase_count;  // Data before strobe, 1..4
		logic [LONG_W-1:0]  strobe_phase_count;      // Strobe low, 1..16
		logic [SHORT_W-1:0] hold_phase_count;        // Hold after strobe, 1..4
		logic [LONG_W-1:0]  recovery_phase_count;    // Gap after access, 1..16
	} phase_cfg_t;

	// One access as asked by the user side
	typedef struct packed {
		logic            write;  // High for a write
		logic [AD_W-1:0] addr;   // Address put out during the latch pulse
		logic [AD_W-1:0] wdata;  // Data put out on a write
	} access_t;

	// Pins facing the peripheral
	typedef struct packed {
		logic            address_latch_pulse;  // High while address latches
		logic            sel_n;                // Chip select, active low
		logic            rnw;                  // High for read, low for write
		logic            data_strobe_n;        // Data strobe, active low
		logic [AD_W-1:0] ad_out;               // Value driven on the lines
		logic            ad_oe_n;              // Low while the lines are driven
	} bus_pins_t;

endpackage

//--- verif/periph_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Peripheral on the shared lines: answers a selected read while strobed
module periph_model (
	input  wire logic                            clk,      // System clock
	input  wire strobe_bus_pkg::bus_pins_t       pins,     // Device pins
	input  wire logic [strobe_bus_pkg::AD_W-1:0] rd_word,  // Word to answer with
	input  wire logic [3:0]                      lag,      // Clocks before driving
	output logic                                 drv_oe_n, // Low while driving
	output logic [strobe_bus_pkg::AD_W-1:0]      drv_ad    // Value driven
);
	import strobe_bus_pkg::*;
	logic [3:0] wait_q; // Clocks since strobe fell
	logic       sel_rd; // Selected read with strobe low
	assign sel_rd = !pins.sel_n && pins.rnw && !pins.data_strobe_n;
	// A slow answer holds off; the lines are let go as soon as the strobe rises
	always @(posedge clk) begin
		if (!sel_rd) wait_q <= 4'h0;
		else if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
	end
	assign drv_oe_n = !(sel_rd && wait_q >= lag);
	assign drv_ad   = rd_word;
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	import strobe_bus_pkg::*;
	logic            clk = 1'b0;         // System clock
	logic            bus_clk = 1'b0;     // Expansion bus clock
	logic            rst_n = 1'b0;       // Reset, low active
	phase_cfg_t      phase_cfg = '0;     // Phase counts
	logic            req_valid = 1'b0;   // Request
	access_t         req = '0;           // Request details
	logic            req_ready;          // Idle flag
	logic            busy;               // Access running
	logic [AD_W-1:0] rd_data;            // Read result
	logic            rd_valid;           // Read pulse
	bus_pins_t       pins;               // Device pins
	logic [AD_W-1:0] ad_wire;            // Resolved shared lines
	logic [AD_W-1:0] last_q = '0;        // Previous line level
	logic [AD_W-1:0] rd_word = 16'h0000; // Peripheral answer
	logic [3:0]      lag = 4'h0;         // Peripheral delay
	logic            p_oe_n;             // Peripheral enable
	logic [AD_W-1:0] p_ad;               // Peripheral value
	logic [20:0]     log_q[$];           // Pins sampled once a bus cycle
	int              n_fail = 0;         // Mismatches
	int              check_count = 0;    // Comparisons
	int              cyc = 0;            // Cycle count
	int              pulses = 0;         // Read pulses seen
	always #12.5 clk = ~clk;
	// Bus clock runs free with a phase unrelated to clk
	initial #37.3 forever #100 bus_clk = ~bus_clk;
	// Released lines show a changing pattern so a stale value never passes
	assign ad_wire = !pins.ad_oe_n ? pins.ad_out : (!p_oe_n ? p_ad : ~last_q);
	always @(posedge clk) last_q <= ad_wire;
	// Pins change a few clocks after a bus edge, so they are settled here
	always @(posedge bus_clk) log_q.push_back({busy, pins.address_latch_pulse, pins.sel_n,
		pins.data_strobe_n, pins.rnw, ad_wire});
	strobe_bus_seq u_dut (
		.clk       (clk),
		.rst_n     (rst_n),
		.bus_clk   (bus_clk),
		.phase_cfg (phase_cfg),
		.req_valid (req_valid),
		.req_ready (req_ready),
		.req       (req),
		.busy      (busy),
		.rd_data   (rd_data),
		.rd_valid  (rd_valid),
		.ad_in     (ad_wire),
		.pins      (pins)
	);
	periph_model u_periph (
		.clk      (clk),
		.pins     (pins),
		.rd_word  (rd_word),
		.lag      (lag),
		.drv_oe_n (p_oe_n),
		.drv_ad   (p_ad)
	);
	////////////////////////////////////////
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Cut a hang short; also count read pulses
	always @(posedge clk) begin
		cyc++;
		if (rd_valid === 1'b1) pulses++;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Holds the request from a rising edge until it is taken
	task automatic take(input access_t a, input phase_cfg_t c);
		int k;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= a;
		phase_cfg <= c;
		for (k = 0; k < 3000; k++) begin
			@(negedge clk);
			if (req_ready === 1'b1) break;
		end
		check_val("request taken", 1'b1, req_ready);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	task automatic wait_idle();
		int k;
		@(negedge clk);
		for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk);
		repeat (2) @(posedge bus_clk);
	endtask
	// Walks the logged bus cycles from the next latch pulse through recovery
	task automatic check_log(input access_t a, input phase_cfg_t c, input int extra, inout int i);
		int n;
		int k;
		int exp_len [6];
		logic [3:0] code;
		exp_len = '{c.address_phase_count + 1, 1, c.data_setup_phase_count + 1,
			c.strobe_phase_count + 1, c.hold_phase_count + 1, c.recovery_phase_count + 1 + extra};
		while (i < log_q.size() && log_q[i][19] !== 1'b1) i++;
		for (k = 0; k < 6; k++) begin
			code = log_q[i][20:17];
			n = 0;
			while (i < log_q.size() && log_q[i][20:17] === code) begin
				if (k < 5) check_val("direction", !a.write, log_q[i][16]);
				if (k < 2) check_val("address", a.addr, log_q[i][15:0]);
				if (k > 1 && k < 5 && a.write) check_val("wdata", a.wdata, log_q[i][15:0]);
				i++;
				n++;
			end
			check_val("phase length", exp_len[k], n);
		end
	endtask
	task automatic run_one(input access_t a, input phase_cfg_t c);
		int i;
		int p;
		i = 0;
		p = pulses;
		log_q.delete();
		take(a, c);
		wait_idle();
		check_log(a, c, 0, i);
		if (!a.write) begin
			check_val("read data", rd_word, rd_data);
		end
		check_val("read pulses", p + (a.write ? 0 : 1), pulses);
	endtask
	task automatic check_idle();
		check_val("idle pins", {RST_LATCH, RST_SEL_N, RST_DS_N, RST_OE_N, 1'b0},
			{pins.address_latch_pulse, pins.sel_n, pins.data_strobe_n, pins.ad_oe_n, busy});
	endtask
	////////////////////////////////////////
	task automatic t_write_short();
		run_one(access_t'({1'b1, 16'h1234, 16'habcd}), phase_cfg_t'(14'h0000));
	endtask
	task automatic t_write_long();
		run_one(access_t'({1'b1, 16'hfedc, 16'h0001}), phase_cfg_t'(14'h3fff));
	endtask
	task automatic t_read_prompt();
		lag <= 4'h0;
		rd_word <= 16'hc3a5;
		run_one(access_t'({1'b0, 16'h0f0f, 16'h0000}), phase_cfg_t'({2'h1, 2'h3, 4'h0, 2'h3, 4'h1}));
	endtask
	// Peripheral answers late in a longer strobe
	task automatic t_read_slow();
		lag <= 4'h8;
		rd_word <= 16'h5a0f;
		run_one(access_t'({1'b0, 16'h8001, 16'h0000}), phase_cfg_t'({2'h3, 2'h0, 4'h3, 2'h0, 4'h7}));
		lag <= 4'h0;
	endtask
	// Second request waits while busy; its counts arrive mid-access and must not disturb the first
	task automatic t_back_to_back();
		int i;
		access_t a1;
		access_t a2;
		phase_cfg_t c1;
		phase_cfg_t c2;
		i = 0;
		a1 = access_t'({1'b1, 16'h5a5a, 16'h0ff0});
		a2 = access_t'({1'b0, 16'ha5a5, 16'h0000});
		c1 = phase_cfg_t'({2'h2, 2'h0, 4'h2, 2'h1, 4'h0});
		c2 = phase_cfg_t'({2'h0, 2'h1, 4'h0, 2'h2, 4'h3});
		rd_word <= 16'h3c3c;
		log_q.delete();
		take(a1, c1);
		take(a2, c2);
		wait_idle();
		check_log(a1, c1, 1, i);
		check_log(a2, c2, 0, i);
		check_val("read data", 16'h3c3c, rd_data);
	endtask
	task automatic t_reset_mid();
		take(access_t'({1'b1, 16'h7777, 16'h8888}), phase_cfg_t'(14'h3fff));
		repeat (40) @(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		check_idle();
		@(posedge clk);
		rst_n <= 1'b1;
		t_write_short();
	endtask
	initial begin
		repeat (4) @(posedge clk);
		check_idle();
		rst_n <= 1'b1;
		t_write_short();
		t_write_long();
		t_read_prompt();
		t_read_slow();
		t_back_to_back();
		t_reset_mid();
		give_verdict();
	end
endmodule
